// ===== include/sld_pkg.sv
// Package: constants and types for the serial LED stream driver
package sld_pkg;
    // ==========================================
    // Stream frame layout
    localparam int FRAME_BITS = 16;
    localparam int FAB_PORTS = 4;
    localparam int SFP_PORTS = 4;
    // Bit positions inside a frame: per port {link_act, port_status}
    localparam int FAB_LINK_BASE = 0;
    localparam int FAB_STAT_BASE = 4;
    localparam int BASE_XFP_LINK_BIT = 0;
    localparam int BASE_XFP_STAT_BIT = 1;
    localparam int SFP_LINK_BASE = 2;
    localparam int SFP_STAT_BASE = 6;
    // Activity bits share frame with link bits at these offsets
    localparam int FAB_ACT_BASE = 8;
    localparam int BASE_XFP_ACT_BIT = 10;
    localparam int SFP_ACT_BASE = 11;

    // ==========================================
    // Timing
    localparam int CLK_HZ = 40000000;
    localparam int BLINK_MS = 50;
    localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
    // Idle gap on stream clock that closes a frame
    localparam int GAP_NS = 2000;
    localparam int GAP_CYCLES = GAP_NS * (CLK_HZ / 1000000) / 1000;

    // ==========================================
    // Revision port
    localparam logic [7:0] REV_ID = 8'h01; // Arbitrary value
    localparam logic RD_BIT = 1'b1;

    // ==========================================
    // Types
    typedef struct packed {
        logic sclk;
        logic sdat;
    } sld_stream_type;

    typedef struct packed {
        logic [FAB_PORTS-1:0] fab_link_act;
        logic [FAB_PORTS-1:0] fab_status;
        logic base_xfp_link_act;
        logic base_xfp_status;
        logic [SFP_PORTS-1:0] sfp_link_act;
        logic [SFP_PORTS-1:0] sfp_status;
    } sld_leds_type;

    typedef enum logic [1:0] {
        SPI_CMD = 2'b00,
        SPI_DATA = 2'b01,
        SPI_IGNORE = 2'b10
    } sld_spi_state_type;
endpackage

// ===== src/sld_driver.sv
// Serial LED stream driver: two LED streams to front-panel LEDs, rear pass-through, revision port
//
// Contract
// - Fabric and base LED streams are received by two separate, independent paths.
// - Each stream is a clock and data pair, data sampled on each rising stream clock.
// - Each used bit position of a latched frame drives exactly one LED; fabric bits 12-15 and base bit 15 are unused.
// - Both streams are forwarded unchanged to the rear module connector.
// - A three-wire serial port lets a master read the revision identifier.
// - Write transfers on the serial port change nothing.
// - Fabric XFP port-status LEDs are lit while link is good, dark otherwise.
// - Fabric XFP link/activity LEDs are steady when enabled, blink on traffic, dark otherwise.
// - The base XFP link/activity LED is steady when enabled, blinks on activity, dark otherwise.
// - The base XFP port-status LED is lit while link is good, dark otherwise.
// - Base SFP port-status LEDs are lit while the port is enabled.
// - Base SFP link/activity LEDs are lit on link, blink on activity, dark otherwise.
// - Each fabric XFP port has one link/activity and one port-status LED.
`timescale 1ns/10ps
module sld_driver
    import sld_pkg::*;
#(
    parameter int BLINK_COUNT = BLINK_CYCLES,
    parameter int GAP_COUNT = GAP_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // LED streams from the switches
    input wire sld_pkg::sld_stream_type fab_stream,
    input wire sld_pkg::sld_stream_type base_stream,
    // Pass-through to the rear_io_module
    output sld_pkg::sld_stream_type rear_fab_stream,
    output sld_pkg::sld_stream_type rear_base_stream,
    // Front-panel LEDs, high is lit
    output sld_pkg::sld_leds_type leds,
    // Three-wire revision port
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe
);
    import sld_pkg::*;

    // ==========================================
    // Input synchronisers
    logic [1:0] fab_s1_reg, fab_s2_reg, base_s1_reg, base_s2_reg;
    logic [2:0] spi_s1_reg, spi_s2_reg;
    logic [1:0] fab_s3_reg, base_s3_reg;
    logic [2:0] spi_s3_reg;
    always_ff @(posedge clk) begin
        fab_s1_reg <= {fab_stream.sclk, fab_stream.sdat};
        fab_s2_reg <= fab_s1_reg;
        fab_s3_reg <= fab_s2_reg;
        base_s1_reg <= {base_stream.sclk, base_stream.sdat};
        base_s2_reg <= base_s1_reg;
        base_s3_reg <= base_s2_reg;
        spi_s1_reg <= {spi_cs_n, spi_sclk, spi_sdio_in};
        spi_s2_reg <= spi_s1_reg;
        spi_s3_reg <= spi_s2_reg;
    end

    // ==========================================
    // Rear pass-through, registered copy of the synchronised stream
    always_ff @(posedge clk) begin
        if (reset) begin
            rear_fab_stream <= '0;
            rear_base_stream <= '0;
        end else begin
            rear_fab_stream <= fab_s2_reg;
            rear_base_stream <= base_s2_reg;
        end
    end

    // ==========================================
    // Frame receivers; a frame ends on a quiet stream clock
    logic [FRAME_BITS-1:0] fab_sh_reg, fab_sh_next, base_sh_reg, base_sh_next;
    logic [FRAME_BITS-1:0] fab_frame_reg, fab_frame_next, base_frame_reg, base_frame_next;
    logic [15:0] fab_gap_reg, fab_gap_next, base_gap_reg, base_gap_next;
    logic fab_any_reg, fab_any_next, base_any_reg, base_any_next;
    logic fab_rise, base_rise;

    assign fab_rise = fab_s2_reg[1] & ~fab_s3_reg[1];
    assign base_rise = base_s2_reg[1] & ~base_s3_reg[1];

    always_comb begin
        fab_sh_next = fab_sh_reg;
        fab_frame_next = fab_frame_reg;
        fab_gap_next = fab_gap_reg;
        fab_any_next = fab_any_reg;
        if (fab_rise) begin
            fab_sh_next = {fab_sh_reg[FRAME_BITS-2:0], fab_s2_reg[0]};
            fab_gap_next = '0;
            fab_any_next = 1'b1;
        end else if (fab_gap_reg < 16'(GAP_COUNT)) begin
            fab_gap_next = fab_gap_reg + 16'h0001;
        end else if (fab_any_reg) begin
            fab_frame_next = fab_sh_reg;
            fab_any_next = 1'b0;
        end
        base_sh_next = base_sh_reg;
        base_frame_next = base_frame_reg;
        base_gap_next = base_gap_reg;
        base_any_next = base_any_reg;
        if (base_rise) begin
            base_sh_next = {base_sh_reg[FRAME_BITS-2:0], base_s2_reg[0]};
            base_gap_next = '0;
            base_any_next = 1'b1;
        end else if (base_gap_reg < 16'(GAP_COUNT)) begin
            base_gap_next = base_gap_reg + 16'h0001;
        end else if (base_any_reg) begin
            base_frame_next = base_sh_reg;
            base_any_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fab_sh_reg <= '0;
            fab_frame_reg <= '0;
            fab_gap_reg <= '0;
            fab_any_reg <= 1'b0;
            base_sh_reg <= '0;
            base_frame_reg <= '0;
            base_gap_reg <= '0;
            base_any_reg <= 1'b0;
        end else begin
            fab_sh_reg <= fab_sh_next;
            fab_frame_reg <= fab_frame_next;
            fab_gap_reg <= fab_gap_next;
            fab_any_reg <= fab_any_next;
            base_sh_reg <= base_sh_next;
            base_frame_reg <= base_frame_next;
            base_gap_reg <= base_gap_next;
            base_any_reg <= base_any_next;
        end
    end

    // ==========================================
    // Blink generator; shared phase keeps all link/activity LEDs in step
    logic [31:0] blink_cnt_reg, blink_cnt_next;
    logic blink_reg, blink_next;
    always_comb begin
        blink_cnt_next = blink_cnt_reg + 32'h00000001;
        blink_next = blink_reg;
        if (blink_cnt_reg >= 32'(BLINK_COUNT - 1)) begin
            blink_cnt_next = '0;
            blink_next = ~blink_reg;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
        end else begin
            blink_cnt_reg <= blink_cnt_next;
            blink_reg <= blink_next;
        end
    end

    // Steady when link, dark during the off phase of activity
    function automatic logic link_act(input logic link, input logic act, input logic ph);
        return link & ~(act & ph);
    endfunction

    // ==========================================
    // LED mapping, one frame bit per status LED, a link bit and an activity bit per link/activity LED
    sld_leds_type leds_next;
    always_comb begin
        for (int i = 0; i < FAB_PORTS; i++) begin
            leds_next.fab_status[i] = fab_frame_reg[FAB_STAT_BASE+i];
            leds_next.fab_link_act[i] = link_act(fab_frame_reg[FAB_LINK_BASE+i],
                fab_frame_reg[FAB_ACT_BASE+i], blink_reg);
        end
        leds_next.base_xfp_status = base_frame_reg[BASE_XFP_STAT_BIT];
        leds_next.base_xfp_link_act = link_act(base_frame_reg[BASE_XFP_LINK_BIT],
            base_frame_reg[BASE_XFP_ACT_BIT], blink_reg);
        for (int i = 0; i < SFP_PORTS; i++) begin
            leds_next.sfp_status[i] = base_frame_reg[SFP_STAT_BASE+i];
            leds_next.sfp_link_act[i] = link_act(base_frame_reg[SFP_LINK_BASE+i],
                base_frame_reg[SFP_ACT_BASE+i], blink_reg);
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            leds <= '0;
        end else begin
            leds <= leds_next;
        end
    end

    // ==========================================
    // Revision port: 8 command bits, MSB first, top bit set means read
    sld_spi_state_type spi_st_reg, spi_st_next;
    logic [2:0] spi_cnt_reg, spi_cnt_next;
    logic [7:0] spi_sh_reg, spi_sh_next;
    logic spi_out_next, spi_oe_next;
    logic spi_rise, spi_fall, spi_sel;
    assign spi_sel = ~spi_s2_reg[2];
    assign spi_rise = spi_s2_reg[1] & ~spi_s3_reg[1];
    assign spi_fall = ~spi_s2_reg[1] & spi_s3_reg[1];

    always_comb begin
        spi_st_next = spi_st_reg;
        spi_cnt_next = spi_cnt_reg;
        spi_sh_next = spi_sh_reg;
        spi_out_next = spi_sdio_out;
        spi_oe_next = spi_sdio_oe;
        if (!spi_sel) begin
            spi_st_next = SPI_CMD;
            spi_cnt_next = '0;
            spi_oe_next = 1'b0;
            spi_out_next = 1'b0;
        end else begin
            case (spi_st_reg)
                SPI_CMD: begin
                    if (spi_rise) begin
                        spi_sh_next = {spi_sh_reg[6:0], spi_s2_reg[0]};
                        spi_cnt_next = spi_cnt_reg + 3'h1;
                        if (spi_cnt_reg == 3'h7) begin
                            if (spi_sh_reg[6] == RD_BIT) begin
                                spi_st_next = SPI_DATA;
                                spi_sh_next = REV_ID;
                            end else begin
                                spi_st_next = SPI_IGNORE;
                            end
                        end
                    end
                end
                SPI_DATA: begin
                    if (spi_fall) begin
                        spi_oe_next = 1'b1;
                        spi_out_next = spi_sh_reg[7];
                        spi_sh_next = {spi_sh_reg[6:0], 1'b0};
                    end
                end
                SPI_IGNORE: spi_st_next = SPI_IGNORE;
                default: spi_st_next = SPI_CMD;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            spi_st_reg <= SPI_CMD;
            spi_cnt_reg <= '0;
            spi_sh_reg <= '0;
            spi_sdio_out <= 1'b0;
            spi_sdio_oe <= 1'b0;
        end else begin
            spi_st_reg <= spi_st_next;
            spi_cnt_reg <= spi_cnt_next;
            spi_sh_reg <= spi_sh_next;
            spi_sdio_out <= spi_out_next;
            spi_sdio_oe <= spi_oe_next;
        end
    end

    // ==========================================
    // Checks
    chk_frame_hold: assert property (@(posedge clk) disable iff (reset)
        fab_rise |=> $stable(fab_frame_reg)) else $error("fabric frame changed mid shift");
    chk_fab_status_map: assert property (@(posedge clk) disable iff (reset)
        ##1 leds.fab_status == $past(fab_frame_reg[FAB_STAT_BASE +: FAB_PORTS]))
        else $error("fabric status LED mismatch");
    chk_base_status_map: assert property (@(posedge clk) disable iff (reset)
        ##1 leds.base_xfp_status == $past(base_frame_reg[BASE_XFP_STAT_BIT]))
        else $error("base xfp status LED mismatch");
    chk_sfp_status_map: assert property (@(posedge clk) disable iff (reset)
        ##1 leds.sfp_status == $past(base_frame_reg[SFP_STAT_BASE +: SFP_PORTS]))
        else $error("sfp status LED mismatch");
    chk_link_dark: assert property (@(posedge clk) disable iff (reset)
        !fab_frame_reg[FAB_LINK_BASE] |=> !leds.fab_link_act[0]) else $error("link LED lit without link");
    chk_base_link_dark: assert property (@(posedge clk) disable iff (reset)
        !base_frame_reg[BASE_XFP_LINK_BIT] |=> !leds.base_xfp_link_act) else $error("base link LED lit");
    chk_sfp_steady: assert property (@(posedge clk) disable iff (reset)
        base_frame_reg[SFP_LINK_BASE] && !base_frame_reg[SFP_ACT_BASE] |=> leds.sfp_link_act[0])
        else $error("sfp link LED not steady");
    chk_rear_copy: assert property (@(posedge clk) disable iff (reset)
        ##1 rear_fab_stream == $past(fab_s2_reg)) else $error("rear stream not forwarded");
    chk_write_silent: assert property (@(posedge clk) disable iff (reset)
        spi_st_reg == SPI_IGNORE |=> !spi_sdio_oe && $stable(spi_sh_reg)) else $error("drive during write");
    chk_shift_in: assert property (@(posedge clk) disable iff (reset)
        fab_rise |=> fab_sh_reg[0] == $past(fab_s2_reg[0])) else $error("stream bit not sampled");
endmodule

// ===== test/sld_driver_bench.sv
// Self-checking bench for the serial LED stream driver
`timescale 1ns/10ps
module sld_driver_bench;
    import sld_pkg::*;
    localparam int GAP = 16;
    localparam int BLK = 8;
    logic clk;
    logic reset;
    sld_stream_type fab_stream;
    sld_stream_type base_stream;
    sld_stream_type rear_fab_stream;
    sld_stream_type rear_base_stream;
    sld_stream_type [2:0] hist_f;
    sld_stream_type [2:0] hist_b;
    sld_leds_type leds;
    logic spi_cs_n;
    logic spi_sclk;
    logic host_drv;
    logic spi_sdio_out;
    logic spi_sdio_oe;
    logic rear_on;
    wire logic spi_sdio_in;
    int fails;
    int n_compared;

    // Shared data wire of the revision port
    assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : host_drv;

    sld_driver #(.BLINK_COUNT(BLK), .GAP_COUNT(GAP)) DUT (.clk(clk), .reset(reset), .fab_stream(fab_stream),
        .base_stream(base_stream), .rear_fab_stream(rear_fab_stream), .rear_base_stream(rear_base_stream),
        .leds(leds), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdio_in(spi_sdio_in),
        .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe));
    sld_switch_model u_fab (.clk(clk), .strm(fab_stream));
    sld_switch_model u_base (.clk(clk), .strm(base_stream));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // =========================================
    // Comparison helpers
    task automatic bad(input string m);
        fails++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic cmp_leds(input sld_leds_type a, input sld_leds_type e, input string m);
        n_compared++;
        if (a !== e) bad(m);
    endtask
    task automatic cmp_byte(input logic [7:0] a, input logic [7:0] e, input string m);
        n_compared++;
        if (a !== e) bad(m);
    endtask
    task automatic cmp_stream(input sld_stream_type a, input sld_stream_type e, input string m);
        n_compared++;
        if (a !== e) bad(m);
    endtask

    function automatic sld_leds_type exp_leds(input logic [15:0] f, input logic [15:0] b, input logic bl);
        sld_leds_type e;
        e.fab_link_act = f[FAB_LINK_BASE +: 4] & ~(f[FAB_ACT_BASE +: 4] & {4{bl}});
        e.fab_status = f[FAB_STAT_BASE +: 4];
        e.base_xfp_link_act = b[BASE_XFP_LINK_BIT] & ~(b[BASE_XFP_ACT_BIT] & bl);
        e.base_xfp_status = b[BASE_XFP_STAT_BIT];
        e.sfp_link_act = b[SFP_LINK_BASE +: 4] & ~(b[SFP_ACT_BASE +: 4] & {4{bl}});
        e.sfp_status = b[SFP_STAT_BASE +: 4];
        return e;
    endfunction

    // Rear copy trails the pin by three edges; judged at the falling edge, where it has settled
    always @(posedge clk) begin
        hist_f <= {hist_f[1:0], fab_stream};
        hist_b <= {hist_b[1:0], base_stream};
    end
    always @(negedge clk) begin
        if (rear_on) cmp_stream(rear_fab_stream, hist_f[2], "rear fabric copy");
        if (rear_on) cmp_stream(rear_base_stream, hist_b[2], "rear base copy");
    end

    task automatic settle;
        repeat (GAP + 12) @(negedge clk);
    endtask

    // =========================================
    // Scenarios
    task automatic t_frames;
        fork
            u_fab.send_frame(16'h806A);
            u_base.send_frame(16'h8315);
        join
        settle;
        cmp_leds(leds, exp_leds(16'h806A, 16'h8315, 1'b0), "decode");
        fork
            u_fab.send_frame(16'h0095);
            begin
                repeat (64) @(negedge clk);
                cmp_leds(leds, exp_leds(16'h806A, 16'h8315, 1'b0), "mid-frame change");
            end
        join
        settle;
        cmp_leds(leds, exp_leds(16'h0095, 16'h8315, 1'b0), "fabric only");
        $display("test frames done");
    endtask

    task automatic t_blink;
        sld_leds_type any_on;
        sld_leds_type all_on;
        fork
            u_fab.send_frame(16'h030F);
            u_base.send_frame(16'h0C3F);
        join
        settle;
        any_on = '0;
        all_on = '1;
        repeat (40) begin
            @(negedge clk);
            any_on = any_on | leds;
            all_on = all_on & leds;
        end
        cmp_leds(any_on, exp_leds(16'h030F, 16'h0C3F, 1'b0), "blink lit");
        cmp_leds(all_on, exp_leds(16'h030F, 16'h0C3F, 1'b1), "blink dark");
        $display("test blink done");
    endtask

    task automatic spi_xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd,
        output logic [15:0] oe_v);
        rd = '0;
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            host_drv = (i > 7) ? cmd[i - 8] : wd[i];
            spi_sclk = 1'b0;
            repeat (6) @(negedge clk);
            oe_v[i] = spi_sdio_oe;
            if (i < 8) rd[i] = spi_sdio_in;
            spi_sclk = 1'b1;
            repeat (4) @(negedge clk);
        end
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask

    task automatic t_spi;
        logic [7:0] rd;
        logic [15:0] oe_v;
        spi_xfer(8'h80, 8'h00, rd, oe_v);
        cmp_byte(rd, REV_ID, "revision read");
        cmp_byte(oe_v[15:8], 8'h00, "drive in command");
        cmp_byte(oe_v[7:0], 8'hFF, "drive in data");
        cmp_byte({7'h00, spi_sdio_oe}, 8'h00, "release");
        spi_xfer(8'h5A, 8'hA5, rd, oe_v);
        cmp_byte(oe_v[15:8] | oe_v[7:0], 8'h00, "drive on write");
        spi_xfer(8'h80, 8'h00, rd, oe_v);
        cmp_byte(rd, REV_ID, "read after write");
        $display("test revision port done");
    endtask

    task automatic end_sim;
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        bad("timeout");
        end_sim;
    end

    initial begin
        reset = 1'b1;
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        host_drv = 1'b0;
        rear_on = 1'b0;
        fails = 0;
        n_compared = 0;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        cmp_leds(leds, '0, "reset state");
        repeat (4) @(negedge clk);
        rear_on = 1'b1;
        t_frames;
        t_blink;
        t_spi;
        end_sim;
    end
endmodule

// ===== test/sld_switch_model.sv
// Switch-side model that shifts serial LED frames into the driver
`timescale 1ns/10ps
module sld_switch_model (
    // Clock
    input wire logic clk,
    // Stream towards the driver
    output sld_pkg::sld_stream_type strm
);
    import sld_pkg::*;

    initial begin
        strm = '0;
    end

    // =========================================
    // Frame sender, first bit is frame bit 15
    task automatic send_frame(input logic [FRAME_BITS-1:0] f);
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            strm.sdat = f[i];
            strm.sclk = 1'b0;
            repeat (4) @(negedge clk);
            strm.sclk = 1'b1;
            repeat (4) @(negedge clk);
        end
        // Clock parks low; stale data shown inverted so it cannot pass by luck
        strm.sclk = 1'b0;
        strm.sdat = ~strm.sdat;
    endtask
endmodule
